/* File: design/lpfc_pkg.sv */
// Purpose: Shared constants and carriers for the link pause flow control block
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes: Pause times are counted in quanta of 512 bit times
package lpfc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] PFC_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PTIME_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;

    // Control register fields
    localparam int CTRL_SYM_BIT = 0;
    localparam int CTRL_ASYM_BIT = 1;
    localparam int CTRL_GEN_BIT = 2;
    localparam int CTRL_RESP_BIT = 3;
    localparam int CTRL_W = 4;

    // Status register fields
    localparam int ST_HOLD_BIT = 0;
    localparam int ST_XOFF_BIT = 1;
    localparam int ST_ERR_BIT = 2;
    localparam int ST_ADV_PAUSE_BIT = 3;
    localparam int ST_ADV_ASYM_BIT = 4;
    localparam int ST_PRIO_LSB = 8;
    localparam int ST_QUANTA_LSB = 16;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int NUM_PRIO = 8;
    localparam int QUANTA_W = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [NUM_PRIO-1:0] PFC_RST = 8'h00;
    localparam logic [QUANTA_W-1:0] PTIME_RST = 16'hFFFF;
    localparam logic [QUANTA_W-1:0] QUANTA_ZERO = 16'h0000;
    localparam logic [QUANTA_W-1:0] QUANTA_ONE = 16'h0001;

    typedef enum logic [3:0] {
        GS_IDLE = 4'h1,
        GS_XOFF_WAIT = 4'h2,
        GS_PAUSING = 4'h4,
        GS_XON_WAIT = 4'h8
    } lpfc_gen_state_t;

    // One pause frame, received or to be sent
    typedef struct packed {
        logic valid;
        logic pfc;
        logic [NUM_PRIO-1:0] prio;
        logic [QUANTA_W-1:0] quanta;
    } lpfc_pause_frame_t;

endpackage

/* File: design/lpfc_port.sv */
// Purpose: Pause and per-priority flow control for one full-duplex port
// Assumes: MAC parses pause frames, builds them on request and gives a quanta tick
// Notes: Instantiate once per physical or aggregate member link
// Behaviour
// - Each port instance holds its own flow control configuration.
// - Pause generation and response work only on a full-duplex link.
// - A received link pause halts every frame regardless of priority.
// - With generation enabled, buffer fullness triggers sending a pause frame.
// - With response enabled, received pause idles transmitter until time expires.
// - A received pause of zero time ends any pause at once; a per-priority one ends only the priorities it names.
// - Buffer drained below release level after pausing sends zero-time pause.
// - Generation and response also serve aggregate member links.
// - Symmetric mode enables generation and response together or neither.
// - Asymmetric mode has separate generation and response enables.
// - Asymmetric mode overrides any symmetric setting on the port.
// - Link pause and per-priority control never coexist; such writes rejected.
// - After reset every form of flow control is disabled.
// - Per-priority control splits traffic into eight 3-bit code point priorities.
// - Each priority has its own per-priority enable, any subset allowed.
// - Priorities without per-priority control keep flowing while others pause.
// - Receive-side enable drives generation, transmit-side enable drives response.
// - Advertise pause and asymmetric bits from the two enables.
`timescale 1ns/10ps
module lpfc_port
    import lpfc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [lpfc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lpfc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lpfc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic link_full_duplex,
    input wire logic quanta_tick,
    input wire logic rx_buf_full,
    input wire logic rx_buf_release,
    input wire lpfc_pkg::lpfc_pause_frame_t rx_pause,
    output lpfc_pkg::lpfc_pause_frame_t tx_pause,
    input wire logic tx_pause_ack,
    output logic tx_hold,
    output logic [lpfc_pkg::NUM_PRIO-1:0] tx_prio_hold,
    output logic advert_pause_bit,
    output logic asymmetric_direction_advert_bit
);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [CTRL_W-1:0] ctrl_reg;
    logic [NUM_PRIO-1:0] pfc_reg;
    logic [QUANTA_W-1:0] ptime_reg;
    logic cfg_err_reg;
    logic gen_en;
    logic resp_en;
    logic wr_gen;
    logic wr_resp;
    logic ctrl_reject;
    logic pfc_reject;

    assign gen_en = ctrl_reg[CTRL_ASYM_BIT] ? ctrl_reg[CTRL_GEN_BIT]
                                            : ctrl_reg[CTRL_SYM_BIT];
    assign resp_en = ctrl_reg[CTRL_ASYM_BIT] ? ctrl_reg[CTRL_RESP_BIT]
                                             : ctrl_reg[CTRL_SYM_BIT];
    assign wr_gen = reg_wdata[CTRL_ASYM_BIT] ? reg_wdata[CTRL_GEN_BIT] : reg_wdata[CTRL_SYM_BIT];
    assign wr_resp = reg_wdata[CTRL_ASYM_BIT] ? reg_wdata[CTRL_RESP_BIT] : reg_wdata[CTRL_SYM_BIT];
    // A write that would leave both kinds of flow control on is dropped whole
    assign ctrl_reject = reg_wr && reg_addr == CTRL_OFS && (wr_gen || wr_resp) && |pfc_reg;
    assign pfc_reject = reg_wr && reg_addr == PFC_OFS && |reg_wdata[NUM_PRIO-1:0]
                        && (gen_en || resp_en);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_reg <= CTRL_RST;
            pfc_reg <= PFC_RST;
            ptime_reg <= PTIME_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == CTRL_OFS && !ctrl_reject)
                ctrl_reg <= reg_wdata[CTRL_W-1:0];
            if (reg_addr == PFC_OFS && !pfc_reject)
                pfc_reg <= reg_wdata[NUM_PRIO-1:0];
            if (reg_addr == PTIME_OFS)
                ptime_reg <= reg_wdata[QUANTA_W-1:0];
        end
    end

    // Sticky error, write one to clear; a new rejection wins over the clear
    always_ff @(posedge mclk)
    begin
        if (srst)
            cfg_err_reg <= 1'b0;
        else if (ctrl_reject || pfc_reject)
            cfg_err_reg <= 1'b1;
        else if (reg_wr && reg_addr == STATUS_OFS && reg_wdata[ST_ERR_BIT])
            cfg_err_reg <= 1'b0;
    end

    // Effective enables: link pause yields to per-priority control, and
    // nothing acts on a half-duplex link
    logic link_gen;
    logic link_resp;
    logic prio_on;
    logic gen_active;

    assign prio_on = |pfc_reg && link_full_duplex;
    assign link_gen = gen_en && !(|pfc_reg) && link_full_duplex;
    assign link_resp = resp_en && !(|pfc_reg) && link_full_duplex;
    assign gen_active = link_gen || prio_on;

    // ****************************************************************
    // Pause generation
    // ****************************************************************
    lpfc_gen_state_t gst_reg;
    lpfc_gen_state_t gst_next;
    logic [QUANTA_W-1:0] refresh_reg;
    logic refresh_due;

    // Resend before the peer's copy of the time runs out while still full
    assign refresh_due = refresh_reg >= (ptime_reg >> 1);

    always_comb
    begin
        gst_next = gst_reg;
        unique case (gst_reg)
            GS_IDLE:
                if (gen_active && rx_buf_full)
                    gst_next = GS_XOFF_WAIT;
            GS_XOFF_WAIT:
                if (tx_pause_ack)
                    gst_next = GS_PAUSING;
            GS_PAUSING:
                if (!gen_active || rx_buf_release)
                    gst_next = GS_XON_WAIT;
                else if (rx_buf_full && refresh_due)
                    gst_next = GS_XOFF_WAIT;
            GS_XON_WAIT:
                if (tx_pause_ack)
                    gst_next = GS_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            gst_reg <= GS_IDLE;
        else
            gst_reg <= gst_next;
    end

    always_ff @(posedge mclk)
    begin
        if (srst || gst_reg != GS_PAUSING)
            refresh_reg <= QUANTA_ZERO;
        else if (quanta_tick && !refresh_due)
            refresh_reg <= refresh_reg + QUANTA_ONE;
    end

    // Frame request stands until the MAC acknowledges it
    always_ff @(posedge mclk)
    begin
        if (srst)
            tx_pause <= '0;
        else if (gst_next == GS_XOFF_WAIT && gst_reg != GS_XOFF_WAIT)
        begin
            tx_pause.valid <= 1'b1;
            tx_pause.pfc <= |pfc_reg;
            tx_pause.prio <= pfc_reg;
            tx_pause.quanta <= ptime_reg;
        end
        else if (gst_next == GS_XON_WAIT && gst_reg != GS_XON_WAIT)
        begin
            tx_pause.valid <= 1'b1;
            tx_pause.quanta <= QUANTA_ZERO;
        end
        else if (tx_pause_ack)
            tx_pause.valid <= 1'b0;
    end

    // ****************************************************************
    // Pause response
    // ****************************************************************
    logic [QUANTA_W-1:0] link_tmr_reg;
    logic [QUANTA_W-1:0] link_tmr_next;
    logic link_load;

    // Each member of an aggregate runs its own copy of this timer
    assign link_load = rx_pause.valid && !rx_pause.pfc;

    always_comb
    begin
        link_tmr_next = link_tmr_reg;
        if (!link_resp)
            link_tmr_next = QUANTA_ZERO;
        else if (link_load)
            link_tmr_next = rx_pause.quanta;
        else if (quanta_tick && link_tmr_reg != QUANTA_ZERO)
            link_tmr_next = link_tmr_reg - QUANTA_ONE;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            link_tmr_reg <= QUANTA_ZERO;
            tx_hold <= 1'b0;
        end
        else
        begin
            link_tmr_reg <= link_tmr_next;
            tx_hold <= link_tmr_next != QUANTA_ZERO;
        end
    end

    // One timer per code point; disabled priorities never hold
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PRIO; gp++)
        begin : g_prio
            logic [QUANTA_W-1:0] tmr_reg;
            logic [QUANTA_W-1:0] tmr_next;
            always_comb
            begin
                tmr_next = tmr_reg;
                if (!(prio_on && pfc_reg[gp]))
                    tmr_next = QUANTA_ZERO;
                else if (rx_pause.valid && rx_pause.pfc && rx_pause.prio[gp])
                    tmr_next = rx_pause.quanta;
                else if (quanta_tick && tmr_reg != QUANTA_ZERO)
                    tmr_next = tmr_reg - QUANTA_ONE;
            end

            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    tmr_reg <= QUANTA_ZERO;
                    tx_prio_hold[gp] <= 1'b0;
                end
                else
                begin
                    tmr_reg <= tmr_next;
                    tx_prio_hold[gp] <= tmr_next != QUANTA_ZERO;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Advertisement and register read
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            advert_pause_bit <= 1'b0;
            asymmetric_direction_advert_bit <= 1'b0;
        end
        else
        begin
            advert_pause_bit <= resp_en;
            asymmetric_direction_advert_bit <= gen_en ^ resp_en;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst || !reg_rd)
            reg_rdata <= '0;
        else
        begin
            reg_rdata <= '0;
            unique case (reg_addr)
                CTRL_OFS: reg_rdata[CTRL_W-1:0] <= ctrl_reg;
                PFC_OFS: reg_rdata[NUM_PRIO-1:0] <= pfc_reg;
                PTIME_OFS: reg_rdata[QUANTA_W-1:0] <= ptime_reg;
                STATUS_OFS:
                begin
                    reg_rdata[ST_HOLD_BIT] <= tx_hold;
                    reg_rdata[ST_XOFF_BIT] <= gst_reg == GS_PAUSING;
                    reg_rdata[ST_ERR_BIT] <= cfg_err_reg;
                    reg_rdata[ST_ADV_PAUSE_BIT] <= advert_pause_bit;
                    reg_rdata[ST_ADV_ASYM_BIT] <= asymmetric_direction_advert_bit;
                    reg_rdata[ST_PRIO_LSB +: NUM_PRIO] <= tx_prio_hold;
                    reg_rdata[ST_QUANTA_LSB +: QUANTA_W] <= link_tmr_reg;
                end
                default: reg_rdata <= '0;
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_xoff_cause;
        gst_reg == GS_IDLE && gen_active && rx_buf_full;
    endsequence
    sequence s_xoff_sent;
        tx_pause.valid && tx_pause.quanta == $past(ptime_reg);
    endsequence
    a_reset_all_off: assert property (@(posedge mclk) srst |=>
        !tx_hold && tx_prio_hold == '0 && !tx_pause.valid && ctrl_reg == CTRL_RST)
        else $error("flow control active after reset");
    a_full_sends_xoff: assert property (@(posedge mclk) disable iff (srst)
        s_xoff_cause |=> s_xoff_sent)
        else $error("no pause frame on full buffer");
    a_release_sends_xon: assert property (@(posedge mclk) disable iff (srst)
        gst_reg == GS_PAUSING && rx_buf_release |=> tx_pause.valid && tx_pause.quanta == '0)
        else $error("no zero pause frame on release");
    a_pause_holds_tx: assert property (@(posedge mclk) disable iff (srst)
        link_resp && link_load && rx_pause.quanta != '0 |=> tx_hold ##1 (tx_hold
        || $past(quanta_tick) || $past(link_load) || !$past(link_resp)))
        else $error("received pause did not hold transmitter");
    a_zero_resumes: assert property (@(posedge mclk) disable iff (srst)
        link_load && rx_pause.quanta == '0 |=> !tx_hold)
        else $error("zero pause did not resume");
    a_half_dup_quiet: assert property (@(posedge mclk) disable iff (srst)
        !link_full_duplex |=> !tx_hold && tx_prio_hold == '0)
        else $error("pause acted on half duplex");
    a_advert_code: assert property (@(posedge mclk) disable iff (srst)
        ##1 advert_pause_bit == $past(resp_en)
        && asymmetric_direction_advert_bit == ($past(gen_en) != $past(resp_en)))
        else $error("advertised bits wrong");
    a_mutex_reject: assert property (@(posedge mclk) disable iff (srst)
        pfc_reject || ctrl_reject |=> cfg_err_reg && !((gen_en || resp_en) && |pfc_reg))
        else $error("conflicting configuration accepted");
    a_asym_override: assert property (@(posedge mclk) disable iff (srst)
        ctrl_reg[CTRL_ASYM_BIT] |-> gen_en == ctrl_reg[CTRL_GEN_BIT]
        && resp_en == ctrl_reg[CTRL_RESP_BIT])
        else $error("symmetric setting not overridden");
    a_prio_only_enabled: assert property (@(posedge mclk) disable iff (srst)
        ##1 (tx_prio_hold & ~$past(pfc_reg)) == '0)
        else $error("priority without control held");
endmodule // lpfc_port

/* File: testbench/lpfc_peer_model.sv */
// Purpose: Behavioural peer node that takes our pause requests and paces quanta
// Assumes: Peer MAC accepts a pause request three cycles after it appears
// Notes: Ticks only while tick_en, so the bench can freeze pause timers
`timescale 1ns/10ps
module lpfc_peer_model
    import lpfc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic tick_en,
    input wire lpfc_pkg::lpfc_pause_frame_t tx_pause,
    output logic tx_pause_ack,
    output logic quanta_tick,
    output logic peer_hold
);
    logic [1:0] div_reg;
    logic [1:0] wait_reg;

    always_ff @(posedge mclk)
    begin
        div_reg <= (srst || !tick_en) ? 2'h0 : div_reg + 2'h1;
        quanta_tick <= tick_en && !srst && (div_reg == 2'h3);
    end

    // Late ack, so the request has to stand for several cycles
    always_ff @(posedge mclk)
    begin
        wait_reg <= (srst || !tx_pause.valid || tx_pause_ack) ? 2'h0 : wait_reg + 2'h1;
        tx_pause_ack <= !srst && tx_pause.valid && !tx_pause_ack && (wait_reg == 2'h2);
    end

    // Peer withholds its frames once a nonzero pause is taken; only a zero-time pause frees it
    always_ff @(posedge mclk)
    begin
        if (srst)
            peer_hold <= 1'b0;
        else if (tx_pause.valid && tx_pause_ack)
            peer_hold <= (tx_pause.quanta != 16'h0000);
    end
endmodule // lpfc_peer_model

/* File: testbench/link_pause_flow_control_tb_top.sv */
// Purpose: Self-checking bench for one pause flow control port
// Assumes: Peer model acks pause requests and makes quanta ticks
// Notes: Ticks are frozen while timer values are read back
`timescale 1ns/10ps
module link_pause_flow_control_tb_top;
    import lpfc_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic link_full_duplex = 1'b1;
    logic quanta_tick;
    logic rx_buf_full = 1'b0;
    logic rx_buf_release = 1'b1;
    lpfc_pause_frame_t rx_pause = '0;
    lpfc_pause_frame_t tx_pause;
    logic tx_pause_ack;
    logic tx_hold;
    logic [NUM_PRIO-1:0] tx_prio_hold;
    logic adv_pause;
    logic adv_asym;
    logic tick_en = 1'b0;
    logic peer_hold;
    int miscompares = 0;
    int n_compared = 0;
    int i;

    always #20 mclk = ~mclk;

    lpfc_port i_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link_full_duplex(link_full_duplex), .quanta_tick(quanta_tick),
        .rx_buf_full(rx_buf_full), .rx_buf_release(rx_buf_release), .rx_pause(rx_pause),
        .tx_pause(tx_pause), .tx_pause_ack(tx_pause_ack), .tx_hold(tx_hold),
        .tx_prio_hold(tx_prio_hold), .advert_pause_bit(adv_pause),
        .asymmetric_direction_advert_bit(adv_asym));

    lpfc_peer_model i_peer (.mclk(mclk), .srst(srst), .tick_en(tick_en),
        .tx_pause(tx_pause), .tx_pause_ack(tx_pause_ack), .quanta_tick(quanta_tick),
        .peer_hold(peer_hold));

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic rxp(input logic pfc, input logic [7:0] pr, input logic [15:0] q);
        @(posedge mclk);
        rx_pause <= '{1'b1, pfc, pr, q};
        @(posedge mclk);
        rx_pause <= '0;
        @(posedge mclk);
        #1;
    endtask

    // Waits for a pause request, checks its time, then waits for the peer to take it
    task automatic txp(input logic [15:0] q);
        for (i = 0; i < 20 && tx_pause.valid !== 1'b1; i++)
            @(posedge mclk);
        #1;
        chk(tx_pause.valid, 1'b1);
        chk(tx_pause.quanta, q);
        for (i = 0; i < 20 && tx_pause.valid !== 1'b0; i++)
            @(posedge mclk);
        #1;
        chk(tx_pause.valid, 1'b0);
    endtask

    task automatic results;
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        rd(CTRL_OFS, 32'h0);
        rd(PFC_OFS, 32'h0);
        rd(PTIME_OFS, 32'h0000FFFF);
        rd(STATUS_OFS, 32'h0);
        rd(8'h10, 32'h0);
        rxp(1'b0, 8'h00, 16'h0007);
        chk(tx_hold, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            wr(CTRL_OFS, {28'h0, k[1:0], 2'h3});
            @(posedge mclk);
            #1;
            chk(adv_pause, k[1]);
            chk(adv_asym, k[0] ^ k[1]);
        end
        wr(CTRL_OFS, 32'h3);
        rxp(1'b0, 8'h00, 16'h0005);
        chk(tx_hold, 1'b0);
        wr(CTRL_OFS, 32'hB);
        rxp(1'b0, 8'h00, 16'h0005);
        chk(tx_hold, 1'b1);
        rxp(1'b0, 8'h00, 16'h0000);
        chk(tx_hold, 1'b0);
        // Symmetric response, timer frozen then counted down
        wr(CTRL_OFS, 32'h1);
        rxp(1'b0, 8'h00, 16'h0002);
        chk(tx_hold, 1'b1);
        rd(STATUS_OFS, 32'h00020009);
        tick_en <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk(tx_hold, 1'b1);
        for (i = 0; i < 20 && tx_hold !== 1'b0; i++)
            @(posedge mclk);
        #1;
        chk(tx_hold, 1'b0);
        tick_en <= 1'b0;
        // Generation: full buffer sends a pause, drained buffer a zero pause
        wr(PTIME_OFS, 32'h5);
        rx_buf_release <= 1'b0;
        rx_buf_full <= 1'b1;
        txp(16'h0005);
        chk(peer_hold, 1'b1);
        rd(STATUS_OFS, 32'h0000000A);
        @(posedge mclk);
        rx_buf_full <= 1'b0;
        rx_buf_release <= 1'b1;
        txp(16'h0000);
        chk(peer_hold, 1'b0);
        // Link pause and per-priority control exclude each other
        wr(PFC_OFS, 32'h0F);
        rd(PFC_OFS, 32'h0);
        rd(STATUS_OFS, 32'h0000000C);
        wr(STATUS_OFS, 32'h4);
        wr(CTRL_OFS, 32'h0);
        wr(PFC_OFS, 32'h05);
        wr(CTRL_OFS, 32'h1);
        rd(CTRL_OFS, 32'h0);
        rd(STATUS_OFS, 32'h4);
        rxp(1'b1, 8'hFF, 16'h0003);
        chk(tx_prio_hold, 8'h05);
        chk(tx_hold, 1'b0);
        rxp(1'b1, 8'h01, 16'h0000);
        chk(tx_prio_hold, 8'h04);
        // Per-priority generation carries the enabled priorities
        @(posedge mclk);
        rx_buf_release <= 1'b0;
        rx_buf_full <= 1'b1;
        txp(16'h0005);
        chk(tx_pause.pfc, 1'b1);
        chk(tx_pause.prio, 8'h05);
        @(posedge mclk);
        rx_buf_full <= 1'b0;
        rx_buf_release <= 1'b1;
        txp(16'h0000);
        // Half duplex blocks both directions
        wr(PFC_OFS, 32'h0);
        wr(CTRL_OFS, 32'h1);
        link_full_duplex <= 1'b0;
        rxp(1'b0, 8'h00, 16'h0009);
        chk(tx_hold, 1'b0);
        @(posedge mclk);
        rx_buf_release <= 1'b0;
        rx_buf_full <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk(tx_pause.valid, 1'b0);
        results();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        results();
    end
endmodule // link_pause_flow_control_tb_top
